// ---- verilog/dma_channel.v ----
// one dma channel: registers, transfer counting and address generation
//
// Notes on behaviour
// - control bit 14 selects memory-to-memory mode when set.
// - control bits 13:12 hold priority: low, medium, high, ultra high.
// - memory width bits 11:10: byte, 16-bit, 32-bit, reserved.
// - peripheral width bits 9:8: byte, 16-bit, 32-bit, reserved.
// - bit 7 set makes the memory address advance after each transfer.
// - bit 6 set makes the peripheral address advance after each transfer.
// - bit 5 set enables circular operation.
// - bit 4 clear moves peripheral to memory, set moves memory to peripheral.
// - bits 3,2,1 enable error, half and full interrupts; bit 0 enables channel.
// - mode, width, stepping, circular and direction fields locked while enabled.
// - priority field also locked while the channel is enabled.
// - count and both base registers ignore writes while enabled.
// - 16-bit remaining count, read-only when enabled, drops per transfer acked without error.
// - a zero remaining count never issues a transfer.
// - circular mode reloads the count from the last programmed value.
// - peripheral base aligned to peripheral width.
// - memory base aligned to memory width.
// - memory-to-memory starts on enable without request, stops at zero; the code reloads and goes on when circular is set.
// - stepping adds 1, 2 or 4 by width; fixed stays at base.
// - channel interrupt when an enabled full, half or error event occurs.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dma_channel (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        periph_req,
    input  wire        xfer_ack,
    input  wire        xfer_error,
    output reg         xfer_req,
    output reg  [31:0] xfer_src_addr,
    output reg  [31:0] xfer_dst_addr,
    output reg  [1:0]  xfer_src_width,
    output reg  [1:0]  xfer_dst_width,
    output reg         xfer_to_periph,
    output reg  [1:0]  channel_priority,
    output reg         full_done_flag,
    output reg         half_done_flag,
    output reg         error_flag,
    output reg         channel_irq
);
`include "dma_chan_defines.vh"

    // ****************************************
    // declarations
    // ****************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg  [`CTL_BITS-1:0] ctl;
    reg  [15:0]          remaining_count;
    reg  [15:0]          programmed_count;
    reg  [31:0]          periph_base;
    reg  [31:0]          mem_base;
    reg  [1:0]           state;
    reg  [1:0]           next_state;
    reg  [31:0]          rd_data;
    reg  [15:0]          next_count;

    wire        wr_pend;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [7:0]  rd_addr;
    wire [31:0] periph_addr;
    wire [31:0] mem_addr;

    wire channel_on           = ctl[`CTL_ON];
    wire full_done_irq_enable = ctl[`CTL_FULL_IE];
    wire half_done_irq_enable = ctl[`CTL_HALF_IE];
    wire error_irq_enable     = ctl[`CTL_ERR_IE];
    wire mem_to_periph        = ctl[`CTL_DIR];
    wire circular_enable      = ctl[`CTL_CIRC];
    wire periph_addr_stepping = ctl[`CTL_PSTEP];
    wire mem_addr_stepping    = ctl[`CTL_MSTEP];
    wire [1:0] periph_width   = ctl[`CTL_PW_LO+1:`CTL_PW_LO];
    wire [1:0] mem_width      = ctl[`CTL_MW_LO+1:`CTL_MW_LO];
    wire mem_to_mem_mode      = ctl[`CTL_M2M];

    // ****************************************
    // register bus front end
    // ****************************************
    ahb_reg_port u_port (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr_low (haddr[7:0]),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rd_data   (rd_data),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_pend   (wr_pend),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .rd_addr   (rd_addr)
    );

    // upper address bits are not decoded; the block mirrors every 256 bytes
    wire wr_ctl    = wr_pend & (wr_addr == `OFS_CTL);
    wire wr_count  = wr_pend & (wr_addr == `OFS_COUNT) & ~channel_on;
    wire wr_pbase  = wr_pend & (wr_addr == `OFS_PBASE) & ~channel_on;
    wire wr_mbase  = wr_pend & (wr_addr == `OFS_MBASE) & ~channel_on;
    wire wr_clear  = wr_pend & (wr_addr == `OFS_CLEAR);
    wire clr_all   = wr_clear & wr_data[`FLG_ANY];
    wire clr_full  = wr_clear & (wr_data[`FLG_FULL] | clr_all);
    wire clr_half  = wr_clear & (wr_data[`FLG_HALF] | clr_all);
    wire clr_err   = wr_clear & (wr_data[`FLG_ERR] | clr_all);

    // ****************************************
    // read mux
    // ****************************************
    // unmapped offsets and reserved bits read as zero
    always @* begin
        case (rd_addr)
            `OFS_STATUS: rd_data = {28'h0000000, error_flag, half_done_flag,
                                    full_done_flag,
                                    error_flag | half_done_flag | full_done_flag};
            `OFS_CTL:    rd_data = {17'h00000, ctl};
            `OFS_COUNT:  rd_data = {16'h0000, remaining_count};
            `OFS_PBASE:  rd_data = periph_base;
            `OFS_MBASE:  rd_data = mem_base;
            default:     rd_data = 32'h00000000;
        endcase
    end

    // ****************************************
    // control word
    // ****************************************
    // only the enables stay writable while the channel runs; an error
    // drops the enable so a broken setup cannot spin
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl <= `CTL_RESET;
        end else if (state == ST_BUSY && xfer_ack && xfer_error) begin
            ctl[`CTL_ON] <= 1'b0;
        end else if (wr_ctl) begin
            if (channel_on) begin
                ctl <= (ctl & ~`CTL_FREE) | (wr_data[`CTL_BITS-1:0] & `CTL_FREE);
            end else begin
                ctl <= wr_data[`CTL_BITS-1:0];
            end
        end
    end

    // ****************************************
    // base address registers
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_base <= `BASE_RESET;
            mem_base    <= `BASE_RESET;
        end else begin
            if (wr_pbase) begin
                periph_base <= wr_data;
            end
            if (wr_mbase) begin
                mem_base <= wr_data;
            end
        end
    end

    // ****************************************
    // transfer sequencing
    // ****************************************
    wire can_issue = channel_on & (remaining_count != 16'h0000)
                     & (mem_to_mem_mode | periph_req);
    wire done_ok   = (state == ST_BUSY) & xfer_ack & ~xfer_error;
    wire done_err  = (state == ST_BUSY) & xfer_ack & xfer_error;
    wire last_one  = done_ok & (next_count == 16'h0000);
    wire reload    = last_one & circular_enable;

    // count after the transfer now finishing
    always @* begin
        next_count = remaining_count - 16'h0001;
    end

    // one transfer outstanding at a time; it completes on the ack
    always @* begin
        case (state)
            ST_IDLE: next_state = can_issue ? ST_BUSY : ST_IDLE;
            ST_BUSY: next_state = xfer_ack ? ST_IDLE : ST_BUSY;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // remaining count
    // ****************************************
    // the programmed copy is kept so circular mode can start over
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remaining_count  <= `COUNT_RESET;
            programmed_count <= `COUNT_RESET;
        end else if (wr_count) begin
            remaining_count  <= wr_data[15:0];
            programmed_count <= wr_data[15:0];
        end else if (reload) begin
            remaining_count <= programmed_count;
        end else if (done_ok) begin
            remaining_count <= next_count;
        end
    end

    // ****************************************
    // address pointers
    // ****************************************
    addr_gen #(
        .AW (32)
    ) u_periph_addr (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .load       (wr_pbase | reload),
        .load_value (wr_pbase ? wr_data : periph_base),
        .step       (done_ok & ~reload),
        .stepping   (periph_addr_stepping),
        .width      (periph_width),
        .base       (periph_base),
        .addr       (periph_addr)
    );

    addr_gen #(
        .AW (32)
    ) u_mem_addr (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .load       (wr_mbase | reload),
        .load_value (wr_mbase ? wr_data : mem_base),
        .step       (done_ok & ~reload),
        .stepping   (mem_addr_stepping),
        .width      (mem_width),
        .base       (mem_base),
        .addr       (mem_addr)
    );

    // drop the low bits that the width makes meaningless
    function [31:0] align;
        input [31:0] a;
        input [1:0]  w;
        begin
            case (w)
                `W_HALF: align = {a[31:1], 1'b0};
                `W_WORD: align = {a[31:2], 2'b00};
                default: align = a;
            endcase
        end
    endfunction

    wire [31:0] periph_aligned = align(periph_addr, periph_width);
    wire [31:0] mem_aligned    = align(mem_addr, mem_width);

    // ****************************************
    // transfer request outputs
    // ****************************************
    // addresses and widths are frozen at issue and held until the ack
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_req       <= 1'b0;
            xfer_src_addr  <= 32'h00000000;
            xfer_dst_addr  <= 32'h00000000;
            xfer_src_width <= `W_BYTE;
            xfer_dst_width <= `W_BYTE;
            xfer_to_periph <= 1'b0;
        end else if (state == ST_IDLE && can_issue) begin
            xfer_req       <= 1'b1;
            xfer_to_periph <= mem_to_periph;
            if (mem_to_periph) begin
                xfer_src_addr  <= mem_aligned;
                xfer_dst_addr  <= periph_aligned;
                xfer_src_width <= mem_width;
                xfer_dst_width <= periph_width;
            end else begin
                xfer_src_addr  <= periph_aligned;
                xfer_dst_addr  <= mem_aligned;
                xfer_src_width <= periph_width;
                xfer_dst_width <= mem_width;
            end
        end else if (xfer_ack) begin
            xfer_req <= 1'b0;
        end
    end

    // ****************************************
    // event flags
    // ****************************************
    // a new event wins over a clear in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_done_flag <= 1'b0;
            half_done_flag <= 1'b0;
            error_flag     <= 1'b0;
        end else begin
            if (last_one) begin
                full_done_flag <= 1'b1;
            end else if (clr_full) begin
                full_done_flag <= 1'b0;
            end
            if (done_ok && next_count == {1'b0, programmed_count[15:1]}) begin
                half_done_flag <= 1'b1;
            end else if (clr_half) begin
                half_done_flag <= 1'b0;
            end
            if (done_err) begin
                error_flag <= 1'b1;
            end else if (clr_err) begin
                error_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // interrupt and priority outputs
    // ****************************************
    // registered from next flag values so the line tracks the flags exactly
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_irq      <= 1'b0;
            channel_priority <= 2'b00;
        end else begin
            channel_priority <= ctl[`CTL_CHANNEL_PRIORITY_LO+1:`CTL_CHANNEL_PRIORITY_LO];
            channel_irq      <= (full_done_irq_enable
                                 & (last_one | (full_done_flag & ~clr_full)))
                              | (half_done_irq_enable
                                 & ((done_ok && next_count ==
                                     {1'b0, programmed_count[15:1]})
                                    | (half_done_flag & ~clr_half)))
                              | (error_irq_enable
                                 & (done_err | (error_flag & ~clr_err)));
        end
    end
endmodule

// ---- verilog/dma_chan_defines.vh ----
// constants shared by the dma channel register and transfer logic
`ifndef DMA_CHAN_DEFINES_VH
`define DMA_CHAN_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_STATUS   8'h00
`define OFS_CLEAR    8'h04
`define OFS_CTL      8'h08
`define OFS_COUNT    8'h0C
`define OFS_PBASE    8'h10
`define OFS_MBASE    8'h14

// ****************************************
// control word fields
// ****************************************
`define CTL_ON       0
`define CTL_FULL_IE  1
`define CTL_HALF_IE  2
`define CTL_ERR_IE   3
`define CTL_DIR      4
`define CTL_CIRC     5
`define CTL_PSTEP    6
`define CTL_MSTEP    7
`define CTL_PW_LO    8
`define CTL_MW_LO    10
`define CTL_CHANNEL_PRIORITY_LO  12
`define CTL_M2M      14
`define CTL_BITS     15
`define CTL_FREE     15'h000F
`define CTL_RESET    15'h0000
`define COUNT_RESET  16'h0000
`define BASE_RESET   32'h00000000

// ****************************************
// status and clear bits
// ****************************************
`define FLG_ANY      0
`define FLG_FULL     1
`define FLG_HALF     2
`define FLG_ERR      3

// ****************************************
// transfer width codes
// ****************************************
`define W_BYTE       2'h0
`define W_HALF       2'h1
`define W_WORD       2'h2
`define HSIZE_WORD   3'h2

`endif

// ---- verilog/ahb_reg_port.v ----
// ahb-lite slave front end: writes with no wait, reads with one wait state
`timescale 1ns/10ps
module ahb_reg_port (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr_low,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    input  wire [31:0] rd_data,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    output reg         wr_pend,
    output reg  [7:0]  wr_addr,
    output wire [31:0] wr_data,
    output reg  [7:0]  rd_addr
);
`include "dma_chan_defines.vh"

    reg  rd_pend;
    wire accept = hsel & hready & htrans[1];

    // write data is only valid in the data phase, so the strobe waits a cycle
    assign wr_data = hwdata;

    // the read wait state lets a write just ahead of it land first
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            rd_pend   <= 1'b0;
            rd_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            wr_pend <= accept & hwrite & (hsize == `HSIZE_WORD);
            if (accept) begin
                wr_addr <= haddr_low;
                rd_addr <= haddr_low;
            end
            if (accept & ~hwrite) begin
                rd_pend   <= 1'b1;
                hreadyout <= 1'b0;
            end else if (rd_pend) begin
                rd_pend   <= 1'b0;
                hrdata    <= rd_data;
                hreadyout <= 1'b1;
            end
        end
    end
endmodule

// ---- verilog/addr_gen.v ----
// one address pointer with fixed or stepping next-address generation
`timescale 1ns/10ps
module addr_gen #(
    parameter AW = 32
) (
    input  wire          hclk,
    input  wire          hresetn,
    input  wire          load,
    input  wire [AW-1:0] load_value,
    input  wire          step,
    input  wire          stepping,
    input  wire [1:0]    width,
    input  wire [AW-1:0] base,
    output reg  [AW-1:0] addr
);
`include "dma_chan_defines.vh"

    reg [AW-1:0] inc;

    // step size follows the transfer width; reserved code steps as a byte
    always @* begin
        case (width)
            `W_HALF: inc = {{(AW-2){1'b0}}, 2'h2};
            `W_WORD: inc = {{(AW-3){1'b0}}, 3'h4};
            default: inc = {{(AW-1){1'b0}}, 1'b1};
        endcase
    end

    // a fixed pointer snaps back to the base after every transfer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr <= {AW{1'b0}};
        end else if (load) begin
            addr <= load_value;
        end else if (step) begin
            addr <= stepping ? addr + inc : base;
        end
    end
endmodule

// ---- testbench/dma_channel_props.sv ----
// assertion checker for the dma channel ports
`timescale 1ns/10ps
`include "dma_chan_defines.vh"
module dma_channel_props (
    input logic        hclk,
    input logic        hresetn,
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic        hreadyout,
    input logic        hresp,
    input logic        xfer_req,
    input logic        xfer_ack,
    input logic        xfer_error,
    input logic [31:0] xfer_src_addr,
    input logic [31:0] xfer_dst_addr,
    input logic [1:0]  xfer_src_width,
    input logic [1:0]  xfer_dst_width,
    input logic        full_done_flag,
    input logic        half_done_flag,
    input logic        error_flag,
    input logic        channel_irq
);
    // ****************************************
    // bus and transfer port relations
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_req_hold: assert property (xfer_req && !xfer_ack |=> xfer_req
        && $stable(xfer_src_addr) && $stable(xfer_dst_addr)) else $error("request moved");
    a_req_drop: assert property (xfer_req && xfer_ack |=> !xfer_req)
        else $error("request held after ack");
    a_err_flag: assert property (xfer_req && xfer_ack && xfer_error |=> error_flag)
        else $error("error flag not set");
    a_full_cause: assert property ($rose(full_done_flag)
        |-> $past(xfer_req && xfer_ack && !xfer_error)) else $error("full flag without ack");
    a_irq_cause: assert property (channel_irq
        |-> (full_done_flag || half_done_flag || error_flag)) else $error("irq without flag");
    a_src_align: assert property (xfer_req && xfer_src_width == `W_HALF
        |-> xfer_src_addr[0] == 1'b0) else $error("source not half aligned");
    a_dst_align: assert property (xfer_req && xfer_dst_width == `W_WORD
        |-> xfer_dst_addr[1:0] == 2'h0) else $error("destination not word aligned");

    // main scenarios reached
    c_read: cover property (hsel && hready && htrans[1] && !hwrite);
    c_err: cover property (xfer_ack && xfer_error && xfer_req);
    c_full: cover property ($rose(full_done_flag));
endmodule

bind dma_channel dma_channel_props i_dma_channel_props (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .xfer_req, .xfer_ack, .xfer_error, .xfer_src_addr, .xfer_dst_addr,
    .xfer_src_width, .xfer_dst_width, .full_done_flag, .half_done_flag,
    .error_flag, .channel_irq
);

// ---- testbench/mem_model.sv ----
// memory system model that answers transfer requests after a set wait
`timescale 1ns/10ps
module mem_model (
    input  logic       hclk,
    input  logic       hresetn,
    input  logic       xfer_req,
    input  logic [3:0] wait_cycles,
    input  logic       fail_next,
    output logic       xfer_ack,
    output logic       xfer_error
);
    logic [3:0] cnt;

    // one ack per request; error line toggles when not qualified by ack
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt        <= 4'h0;
            xfer_ack   <= 1'b0;
            xfer_error <= 1'b0;
        end else begin
            xfer_ack   <= 1'b0;
            xfer_error <= ~xfer_error;
            if (xfer_req && !xfer_ack) begin
                if (cnt >= wait_cycles) begin
                    xfer_ack   <= 1'b1;
                    xfer_error <= fail_next;
                    cnt        <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ---- testbench/tb_dma_channel.sv ----
// self-checking testbench for one dma channel
`timescale 1ns/10ps
`include "dma_chan_defines.vh"
module tb_dma_channel;
    logic        hclk, hresetn, hsel, hwrite, periph_req, fail_next;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  wait_cycles;
    wire         hreadyout, hresp, xfer_req, xfer_ack, xfer_error, xfer_to_periph;
    wire         full_done_flag, half_done_flag, error_flag, channel_irq;
    wire  [31:0] hrdata, xfer_src_addr, xfer_dst_addr;
    wire  [1:0]  xfer_src_width, xfer_dst_width, channel_priority;
    int          miscompares = 0;
    int          n_checks = 0;

    dma_channel i_dma_channel (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .periph_req(periph_req), .xfer_ack(xfer_ack), .xfer_error(xfer_error),
        .xfer_req(xfer_req), .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
        .xfer_src_width(xfer_src_width), .xfer_dst_width(xfer_dst_width),
        .xfer_to_periph(xfer_to_periph), .channel_priority(channel_priority),
        .full_done_flag(full_done_flag), .half_done_flag(half_done_flag),
        .error_flag(error_flag), .channel_irq(channel_irq));
    mem_model i_mem_model (.hclk(hclk), .hresetn(hresetn), .xfer_req(xfer_req),
        .wait_cycles(wait_cycles), .fail_next(fail_next), .xfer_ack(xfer_ack),
        .xfer_error(xfer_error));

    // ****************************************
    // clock, bus and compare helpers
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // single word transfer; master waits for hready in both phases
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsize  <= `HSIZE_WORD;
        hsel   <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(name, rd, exp);
    endtask

    // catch one issued transfer, compare its addresses, wait for it to retire
    task xfer(input logic [31:0] s, input logic [31:0] d, input logic [4:0] kind);
        do @(posedge hclk); while (xfer_req !== 1'b1);
        periph_req <= 1'b0;
        check("src", xfer_src_addr, s);
        check("dst", xfer_dst_addr, d);
        check("kind", {27'h0, xfer_src_width, xfer_dst_width, xfer_to_periph}, kind);
        do @(posedge hclk); while (xfer_req !== 1'b0);
    endtask

    task summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog: whole run needs a few hundred cycles
    initial begin
        #160000;
        miscompares++;
        summarize;
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; periph_req = 1'b0; fail_next = 1'b0;
        wait_cycles = 4'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("count", `OFS_COUNT, 32'h0);
        rchk("pbase", `OFS_PBASE, 32'h0);
        rchk("mbase", `OFS_MBASE, 32'h0);
        rchk("ctl", `OFS_CTL, 32'h0);
        rchk("unmapped", 32'h20, 32'h0);
        $display("test reset values done");
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, `OFS_CTL, 32'h4FFE | (p << 12));
            rchk("ctl", `OFS_CTL, 32'h4FFE | (p << 12));
            check("channel_priority", {30'h0, channel_priority}, p);
        end
        bus(1'b1, `OFS_CTL, 32'h0);
        $display("test control fields done");
        bus(1'b1, `OFS_CTL, 32'h1);
        bus(1'b1, `OFS_CTL, 32'h7FFF);
        rchk("ctl", `OFS_CTL, 32'h000F);
        check("channel_priority", {30'h0, channel_priority}, 32'h0);
        bus(1'b1, `OFS_COUNT, 32'h5);
        bus(1'b1, `OFS_PBASE, 32'h1234);
        rchk("count", `OFS_COUNT, 32'h0);
        rchk("pbase", `OFS_PBASE, 32'h0);
        check("req", {31'h0, xfer_req}, 32'h0);
        bus(1'b1, `OFS_CTL, 32'h0);
        $display("test enable lock done");
        // peripheral to memory, half periph fixed, word memory stepping
        bus(1'b1, `OFS_PBASE, 32'h1003);
        bus(1'b1, `OFS_MBASE, 32'h2002);
        bus(1'b1, `OFS_COUNT, 32'h4);
        bus(1'b1, `OFS_CTL, 32'h987);
        periph_req <= 1'b1;
        xfer(32'h1002, 32'h2000, 5'h0C);
        periph_req <= 1'b1;
        xfer(32'h1002, 32'h2004, 5'h0C);
        bus(1'b1, `OFS_CTL, 32'h986);
        rchk("count", `OFS_COUNT, 32'h2);
        rchk("status", `OFS_STATUS, 32'h5);
        periph_req <= 1'b1;
        repeat (8) @(posedge hclk);
        check("req", {31'h0, xfer_req}, 32'h0);
        periph_req <= 1'b0;
        bus(1'b1, `OFS_CTL, 32'h987);
        periph_req <= 1'b1;
        xfer(32'h1002, 32'h2008, 5'h0C);
        periph_req <= 1'b1;
        xfer(32'h1002, 32'h200C, 5'h0C);
        periph_req <= 1'b1;
        repeat (8) @(posedge hclk);
        check("req", {31'h0, xfer_req}, 32'h0);
        periph_req <= 1'b0;
        rchk("count", `OFS_COUNT, 32'h0);
        rchk("status", `OFS_STATUS, 32'h7);
        check("irq", {31'h0, channel_irq}, 32'h1);
        bus(1'b1, `OFS_CLEAR, 32'h1);
        rchk("status", `OFS_STATUS, 32'h0);
        check("irq", {31'h0, channel_irq}, 32'h0);
        $display("test peripheral transfers done");
        // memory to memory, circular, bytes, slow memory, error at the end
        bus(1'b1, `OFS_CTL, 32'h0);
        wait_cycles <= 4'h2;
        bus(1'b1, `OFS_PBASE, 32'h4000);
        bus(1'b1, `OFS_MBASE, 32'h3001);
        bus(1'b1, `OFS_COUNT, 32'h2);
        bus(1'b1, `OFS_CTL, 32'h40F9);
        xfer(32'h3001, 32'h4000, 5'h01);
        xfer(32'h3002, 32'h4001, 5'h01);
        fail_next <= 1'b1;
        xfer(32'h3001, 32'h4000, 5'h01);
        repeat (4) @(posedge hclk);
        fail_next <= 1'b0;
        rchk("status", `OFS_STATUS, 32'hF);
        rchk("count", `OFS_COUNT, 32'h2);
        rchk("ctl", `OFS_CTL, 32'h40F8);
        check("irq", {31'h0, channel_irq}, 32'h1);
        $display("test memory to memory done");
        summarize;
    end
endmodule
